/* File: logic/tx_mixer_correction_sync.sv */
// Transmit chain: fine mixer, coarse mixer, droop filter, gain/phase
// correction, offset, plus the alignment controller for these stages.
// Assumes all inputs are synchronous to clk_sys except align_pin_pos.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - I=Acos-Bsin, Q=Asin+Bcos from oscillator
// - Oscillator holds 32-bit frequency, 20-bit phase
// - Frequency step is sample rate over 2^32
// - Mode 00 passes, mode 01 negates alternately
// - Mode 10 rotates by plus quarter rate
// - Mode 11 rotates by minus quarter rate
// - Optional nine-tap droop compensation filter
// - Path gains are 11-bit setting over 1024
// - Phase setting times Q added to I
// - Signed 13-bit offset over 16 added
// - Global align on pin rising edge, ordered
// - Register bit rising edge replaces the pin
// - Per-block align when global is disabled
// - Offsets immediate or loaded on alignment
// - Align sets write pointer 0, read 4
// - Align loads gain and phase correction
// - Align loads oscillator words, presets phase
// - Align restarts coarse mixer at start phase
// - Power start waits eight times the setting plus four valid samples after align
// - Works from reset state without alignment
// - Coarse mixer runs on fine mixer output samples
module tx_mixer_correction_sync
  import tx_mixer_pkg::*;
#(
  parameter int DW      = 12,
  parameter int FIFO_AW = 3
)(
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire logic signed [DW-1:0] in_a,
  input  wire logic signed [DW-1:0] in_b,
  input  wire logic                 in_valid,
  input  wire logic                 fine_freq_mixer_enable,
  input  wire logic [FREQ_W-1:0]    fine_freq_word,
  input  wire logic [PHASE_W-1:0]   fine_phase_word,
  input  wire logic [1:0]           coarse_freq_mixer_mode,
  input  wire logic [1:0]           coarse_start_phase,
  input  wire logic                 droop_filter_enable,
  input  wire logic [GAIN_W-1:0]    i_path_gain,
  input  wire logic [GAIN_W-1:0]    q_path_gain,
  input  wire logic [PHB_W-1:0]     iq_phase_balance,
  input  wire logic [OFF_W-1:0]     a_path_dc_shift,
  input  wire logic [OFF_W-1:0]     b_path_dc_shift,
  input  wire logic                 offset_align_needed,
  input  wire logic                 align_pin_pos,
  input  wire logic                 tx_align_all_disable,
  input  wire logic                 tx_align_source_select,
  input  wire logic                 tx_align_reg_bit,
  input  wire logic [NBLK-1:0]      block_align_enable,
  input  wire logic [NBLK-1:0]      block_align_source_select,
  input  wire logic [NBLK-1:0]      block_align_reg_bit,
  input  wire logic                 power_enable,
  input  wire logic                 power_align_enable,
  input  wire logic [PW_DELAY_W-1:0] power_align_delay,
  output logic signed [DW-1:0]      dac_i_q,
  output logic signed [DW-1:0]      dac_q_q,
  output logic                      dac_valid_q,
  output logic                      clkdiv_align_q,
  output logic [FIFO_AW-1:0]        fifo_wr_ptr_q,
  output logic [FIFO_AW-1:0]        fifo_rd_ptr_q,
  output logic                      power_start_q
);

  localparam int IW = DW + 4;
  typedef logic [ISINC_TAPS-1:0][IW-1:0] taps_t;

  function automatic logic signed [15:0] nco_sin(
    input logic [NCO_LUT_W-1:0] p);
    logic [4:0]  idx;
    logic [15:0] mag;
    idx = {1'b0, p[NCO_LUT_W-3:0]};
    mag = p[NCO_LUT_W-2] ? SIN_TAB[QTR_STEPS - idx] : SIN_TAB[idx];
    return p[NCO_LUT_W-1] ? -$signed(mag) : $signed(mag);
  endfunction

  function automatic logic signed [IW-1:0] cmul(
    input logic signed [DW-1:0] x, input logic signed [DW-1:0] y,
    input logic signed [15:0] u, input logic signed [15:0] v);
    logic signed [31:0] s;
    s = 32'(x * u) + 32'(y * v);
    return IW'(s >>> SIN_FRAC);
  endfunction

  function automatic logic signed [31:0] isinc(input taps_t t);
    logic signed [31:0] acc;
    acc = '0;
    for (int k = 0; k < ISINC_TAPS; k++)
    begin
      acc = acc + ISINC_COEF[k] * 32'($signed(t[k]));
    end
    return acc >>> ISINC_SHIFT;
  endfunction

  // Clipping keeps a full-scale overshoot from wrapping to the far rail
  function automatic logic signed [DW-1:0] sat(input logic signed [31:0] x);
    logic signed [31:0] hi;
    logic signed [31:0] lo;
    hi = 32'sd1 <<< (DW - 1);
    lo = -hi;
    hi = hi - 32'sd1;
    if (x > hi)
      return DW'(hi);
    else if (x < lo)
      return DW'(lo);
    else
      return DW'(x);
  endfunction

  // ---------------- Alignment control ----------------
  logic                pin_meta_q;
  logic                pin_sync_q;
  logic                pin_prev_q;
  logic                gbit_prev_q;
  logic [NBLK-1:0]     bbit_prev_q;
  logic [GSEQ_LEN-1:0] gseq_q;
  wire                 pin_pulse;
  wire                 glob_trig;
  wire  [NBLK-1:0]     blk_trig;
  wire  [NBLK-1:0]     glob_blk;
  wire  [NBLK-1:0]     align_hit;

  assign pin_pulse = pin_sync_q & ~pin_prev_q;
  assign glob_trig = ~tx_align_all_disable &
                     (tx_align_source_select ?
                      (tx_align_reg_bit & ~gbit_prev_q) : pin_pulse);
  assign glob_blk = {{(NBLK-2){gseq_q[2]}}, gseq_q[1], gseq_q[0]};
  assign blk_trig = block_align_enable &
                    ((block_align_source_select &
                      block_align_reg_bit & ~bbit_prev_q) |
                     (~block_align_source_select & {NBLK{pin_pulse}}));
  // Host is trusted to order per-block triggers itself
  // order left to host
  assign align_hit = tx_align_all_disable ? blk_trig : glob_blk;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      pin_meta_q     <= 1'b0;
      pin_sync_q     <= 1'b0;
      pin_prev_q     <= 1'b0;
      gbit_prev_q    <= 1'b0;
      bbit_prev_q    <= '0;
      gseq_q         <= '0;
      clkdiv_align_q <= 1'b0;
    end
    else
    begin
      pin_meta_q     <= align_pin_pos;
      pin_sync_q     <= pin_meta_q;
      pin_prev_q     <= pin_sync_q;
      gbit_prev_q    <= tx_align_reg_bit;
      bbit_prev_q    <= block_align_reg_bit;
      gseq_q         <= {gseq_q[GSEQ_LEN-2:0], glob_trig};
      clkdiv_align_q <= align_hit[BLK_CLKDIV];
    end
  end

  // ---------------- Active settings ----------------
  logic [FREQ_W-1:0] freq_act_q;
  logic [FREQ_W-1:0] acc_q;
  logic [GAIN_W-1:0] gain_i_act_q;
  logic [GAIN_W-1:0] gain_q_act_q;
  logic [PHB_W-1:0]  phb_act_q;
  logic [OFF_W-1:0]  off_a_act_q;
  logic [OFF_W-1:0]  off_b_act_q;
  logic [1:0]        cm_ph_q;
  logic              v1_q;
  wire               off_load;

  assign off_load = ~offset_align_needed | align_hit[BLK_OFFSET];

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      freq_act_q   <= '0;
      acc_q        <= '0;
      gain_i_act_q <= GAIN_UNITY;
      gain_q_act_q <= GAIN_UNITY;
      phb_act_q    <= '0;
      off_a_act_q  <= '0;
      off_b_act_q  <= '0;
      cm_ph_q      <= '0;
    end
    else
    begin
      if (align_hit[BLK_FINE])
      begin
        freq_act_q <= fine_freq_word;
        acc_q      <= {fine_phase_word, {(FREQ_W-PHASE_W){1'b0}}};
      end
      else if (in_valid)
        acc_q <= acc_q + freq_act_q;
      if (align_hit[BLK_QUAD])
      begin
        gain_i_act_q <= i_path_gain;
        gain_q_act_q <= q_path_gain;
        phb_act_q    <= iq_phase_balance;
      end
      if (off_load)
      begin
        off_a_act_q <= a_path_dc_shift;
        off_b_act_q <= b_path_dc_shift;
      end
      if (align_hit[BLK_COARSE])
        cm_ph_q <= coarse_start_phase;
      else if (v1_q)
        cm_ph_q <= cm_ph_q + 2'h1;
    end
  end

  // ---------------- Datapath ----------------
  logic signed [IW-1:0] fm_i_q;
  logic signed [IW-1:0] fm_q_q;
  logic signed [IW-1:0] cm_i_d;
  logic signed [IW-1:0] cm_q_d;
  taps_t                taps_i_q;
  taps_t                taps_q_q;
  logic signed [31:0]   is_i_q;
  logic signed [31:0]   is_q_q;
  logic                 v2_q;
  logic                 v3_q;
  wire  [NCO_LUT_W-1:0] nco_p;
  wire  signed [15:0]   nco_s;
  wire  signed [15:0]   nco_c;
  wire  signed [31:0]   gi;
  wire  signed [31:0]   gq;
  wire  signed [31:0]   corr_i;
  wire  signed [31:0]   corr_q;

  assign nco_p = acc_q[FREQ_W-1 -: NCO_LUT_W];
  assign nco_s = nco_sin(nco_p);
  assign nco_c = nco_sin(nco_p + QTR_OFF);

  always_comb
  begin
    cm_i_d = fm_i_q;
    cm_q_d = fm_q_q;
    unique case (coarse_freq_mixer_mode)
      COARSE_NONE: ;
      COARSE_HALF:
      begin
        cm_i_d = cm_ph_q[0] ? -fm_i_q : fm_i_q;
        cm_q_d = cm_ph_q[0] ? -fm_q_q : fm_q_q;
      end
      COARSE_POSQ:
      begin
        unique case (cm_ph_q)
          2'h0: begin cm_i_d =  fm_i_q; cm_q_d =  fm_q_q; end
          2'h1: begin cm_i_d = -fm_q_q; cm_q_d =  fm_i_q; end
          2'h2: begin cm_i_d = -fm_i_q; cm_q_d = -fm_q_q; end
          2'h3: begin cm_i_d =  fm_q_q; cm_q_d = -fm_i_q; end
        endcase
      end
      COARSE_NEGQ:
      begin
        unique case (cm_ph_q)
          2'h0: begin cm_i_d =  fm_i_q; cm_q_d =  fm_q_q; end
          2'h1: begin cm_i_d =  fm_q_q; cm_q_d = -fm_i_q; end
          2'h2: begin cm_i_d = -fm_i_q; cm_q_d = -fm_q_q; end
          2'h3: begin cm_i_d = -fm_q_q; cm_q_d =  fm_i_q; end
        endcase
      end
    endcase
  end

  assign gi = (32'(is_i_q * $signed({1'b0, gain_i_act_q}))) >>> GAIN_SHIFT;
  assign gq = (32'(is_q_q * $signed({1'b0, gain_q_act_q}))) >>> GAIN_SHIFT;
  assign corr_i = gi + ((32'(gq * $signed(phb_act_q))) >>> PHB_SHIFT)
                  + (32'($signed(off_a_act_q)) >>> OFF_SHIFT);
  assign corr_q = gq + (32'($signed(off_b_act_q)) >>> OFF_SHIFT);

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      fm_i_q      <= '0;
      fm_q_q      <= '0;
      taps_i_q    <= '0;
      taps_q_q    <= '0;
      is_i_q      <= '0;
      is_q_q      <= '0;
      v1_q        <= 1'b0;
      v2_q        <= 1'b0;
      v3_q        <= 1'b0;
      dac_i_q     <= '0;
      dac_q_q     <= '0;
      dac_valid_q <= 1'b0;
    end
    else
    begin
      v1_q <= in_valid;
      if (in_valid)
      begin
        fm_i_q <= fine_freq_mixer_enable ?
                  cmul(in_a, in_b, nco_c, -nco_s) : IW'(in_a);
        fm_q_q <= fine_freq_mixer_enable ?
                  cmul(in_a, in_b, nco_s, nco_c) : IW'(in_b);
      end
      v2_q <= v1_q;
      if (v1_q)
      begin
        taps_i_q <= {taps_i_q[ISINC_TAPS-2:0], cm_i_d};
        taps_q_q <= {taps_q_q[ISINC_TAPS-2:0], cm_q_d};
      end
      v3_q <= v2_q;
      if (v2_q)
      begin
        is_i_q <= droop_filter_enable ? isinc(taps_i_q)
                                      : 32'($signed(taps_i_q[0]));
        is_q_q <= droop_filter_enable ? isinc(taps_q_q)
                                      : 32'($signed(taps_q_q[0]));
      end
      dac_valid_q <= v3_q;
      if (v3_q)
      begin
        dac_i_q <= sat(corr_i);
        dac_q_q <= sat(corr_q);
      end
    end
  end

  // ---------------- Buffer pointers and power start ----------------
  logic [PW_CNT_W-1:0] pw_cnt_q;
  logic                pw_busy_q;
  logic                pw_en_prev_q;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      fifo_wr_ptr_q <= FIFO_AW'(FIFO_WR_INIT);
      fifo_rd_ptr_q <= FIFO_AW'(FIFO_RD_INIT);
      pw_cnt_q      <= '0;
      pw_busy_q     <= 1'b0;
      pw_en_prev_q  <= 1'b0;
      power_start_q <= 1'b0;
    end
    else
    begin
      if (align_hit[BLK_FIFO])
      begin
        fifo_wr_ptr_q <= FIFO_AW'(FIFO_WR_INIT);
        fifo_rd_ptr_q <= FIFO_AW'(FIFO_RD_INIT);
      end
      else if (in_valid)
      begin
        fifo_wr_ptr_q <= fifo_wr_ptr_q + 1'b1;
        fifo_rd_ptr_q <= fifo_rd_ptr_q + 1'b1;
      end
      pw_en_prev_q  <= power_enable;
      power_start_q <= 1'b0;
      if (power_enable & power_align_enable & align_hit[BLK_POWER])
      begin
        pw_cnt_q  <= PW_CNT_W'({power_align_delay, {PW_STEP_SHIFT{1'b0}}})
                     + PW_EXTRA;
        pw_busy_q <= 1'b1;
      end
      else if (pw_busy_q & in_valid)
      begin
        pw_cnt_q <= pw_cnt_q - 1'b1;
        if (pw_cnt_q == PW_CNT_W'(1))
        begin
          pw_busy_q     <= 1'b0;
          power_start_q <= 1'b1;
        end
      end
      else if (~power_align_enable & power_enable & ~pw_en_prev_q)
        power_start_q <= 1'b1;
    end
  end

endmodule

`default_nettype wire

/* File: logic/tx_mixer_pkg.sv */
// Constants for the transmit mixer, correction and alignment chain.
// Assumes a single converter clock domain; settings arrive as plain ports.
package tx_mixer_pkg;

  localparam int FREQ_W     = 32;
  localparam int PHASE_W    = 20;
  localparam int GAIN_W     = 11;
  localparam int PHB_W      = 10;
  localparam int OFF_W      = 13;
  localparam int GAIN_SHIFT = 10;
  localparam int PHB_SHIFT  = 12;
  localparam int OFF_SHIFT  = 4;
  localparam logic [GAIN_W-1:0] GAIN_UNITY = 11'h400;

  // Oscillator lookup: 64 points per turn, quarter table of 17 entries
  localparam int NCO_LUT_W = 6;
  localparam int SIN_FRAC  = 14;
  localparam logic [4:0] QTR_STEPS = 5'h10;
  localparam logic [NCO_LUT_W-1:0] QTR_OFF = 6'h10;
  localparam logic [15:0] SIN_TAB [0:16] = '{
    16'h0000, 16'h0646, 16'h0C7C, 16'h1294, 16'h187E, 16'h1E2B,
    16'h238E, 16'h289A, 16'h2D41, 16'h3179, 16'h3537, 16'h3871,
    16'h3B21, 16'h3D3E, 16'h3EC5, 16'h3FB1, 16'h3FFF};

  // Droop compensation, unity gain at DC after the shift
  localparam int ISINC_TAPS  = 9;
  localparam int ISINC_SHIFT = 9;
  localparam logic signed [15:0] ISINC_COEF [0:ISINC_TAPS-1] = '{
    16'sh0001, -16'sh0004, 16'sh000D, -16'sh0032, 16'sh0250,
    -16'sh0032, 16'sh000D, -16'sh0004, 16'sh0001};

  // Coarse mixer modes
  localparam logic [1:0] COARSE_NONE = 2'h0;
  localparam logic [1:0] COARSE_HALF = 2'h1;
  localparam logic [1:0] COARSE_POSQ = 2'h2;
  localparam logic [1:0] COARSE_NEGQ = 2'h3;

  // Alignment targets
  localparam int NBLK       = 7;
  localparam int BLK_CLKDIV = 0;
  localparam int BLK_FIFO   = 1;
  localparam int BLK_OFFSET = 2;
  localparam int BLK_QUAD   = 3;
  localparam int BLK_FINE   = 4;
  localparam int BLK_COARSE = 5;
  localparam int BLK_POWER  = 6;
  localparam int GSEQ_LEN   = 3;

  // Clock-crossing pointer restart values
  localparam int FIFO_WR_INIT = 0;
  localparam int FIFO_RD_INIT = 4;

  // Power start delay: step times the setting plus a fixed extra
  localparam int PW_DELAY_W    = 9;
  localparam int PW_CNT_W      = 12;
  localparam int PW_STEP_SHIFT = 3;
  localparam logic [PW_CNT_W-1:0] PW_EXTRA = 12'h004;

endpackage

/* File: sim/tx_chain_props.sv */
// Port checker for the transmit mixer, correction and alignment chain.
// Assumes it is bound into the chain top module; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module tx_chain_props
  import tx_mixer_pkg::*;
#(
  parameter int DW      = 12,
  parameter int FIFO_AW = 3
)(
  input wire logic                 clk_sys,
  input wire logic                 reset,
  input wire logic                 in_valid,
  input wire logic                 align_pin_pos,
  input wire logic                 tx_align_all_disable,
  input wire logic                 tx_align_source_select,
  input wire logic                 tx_align_reg_bit,
  input wire logic [NBLK-1:0]      block_align_enable,
  input wire logic [NBLK-1:0]      block_align_source_select,
  input wire logic [NBLK-1:0]      block_align_reg_bit,
  input wire logic                 power_enable,
  input wire logic                 power_align_enable,
  input wire logic signed [DW-1:0] dac_i_q,
  input wire logic signed [DW-1:0] dac_q_q,
  input wire logic                 dac_valid_q,
  input wire logic                 clkdiv_align_q,
  input wire logic [FIFO_AW-1:0]   fifo_wr_ptr_q,
  input wire logic [FIFO_AW-1:0]   fifo_rd_ptr_q,
  input wire logic                 power_start_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Pointers move together, so their distance never changes
  wire logic [FIFO_AW-1:0] gap_w = fifo_rd_ptr_q - fifo_wr_ptr_q;
  wire logic               gpin_w = !tx_align_all_disable
                                    && !tx_align_source_select;
  a_valid_latency: assert property (in_valid |-> ##4 dac_valid_q)
    else $error("sample answer missing");
  a_out_hold: assert property (!dac_valid_q |-> $stable(dac_i_q)
    && $stable(dac_q_q)) else $error("output moved without valid");
  a_ptr_gap: assert property (gap_w == 4)
    else $error("pointer distance not four");
  a_pin_align: assert property ($rose(align_pin_pos) && gpin_w
    |-> ##[2:6] clkdiv_align_q) else $error("pin edge not aligned");
  a_reg_align: assert property ($rose(tx_align_reg_bit)
    && !tx_align_all_disable && tx_align_source_select
    |-> ##[1:4] clkdiv_align_q) else $error("reg bit not aligned");
  a_block_align: assert property ($rose(block_align_reg_bit[0])
    && tx_align_all_disable && block_align_enable[0]
    && block_align_source_select[0] |-> ##[1:2] clkdiv_align_q)
    else $error("block bit not aligned");
  a_div_pulse: assert property (clkdiv_align_q |=> !clkdiv_align_q)
    else $error("divider pulse too long");
  a_power_free: assert property ($rose(power_enable)
    && !power_align_enable |-> ##[1:2] power_start_q)
    else $error("power start missing");
  c_power: cover property (power_start_q);
  c_block: cover property (clkdiv_align_q && tx_align_all_disable);
  c_burst: cover property (in_valid [*4]);
endmodule
bind tx_mixer_correction_sync tx_chain_props #(
  .DW(DW),
  .FIFO_AW(FIFO_AW)
) u_props (
  .clk_sys, .reset, .in_valid, .align_pin_pos, .tx_align_all_disable,
  .tx_align_source_select, .tx_align_reg_bit, .block_align_enable,
  .block_align_source_select, .block_align_reg_bit, .power_enable,
  .power_align_enable, .dac_i_q, .dac_q_q, .dac_valid_q, .clkdiv_align_q,
  .fifo_wr_ptr_q, .fifo_rd_ptr_q, .power_start_q
);
`default_nettype wire

/* File: sim/baseband_source.sv */
// Upstream baseband source model feeding the sample stream.
// Assumes its tasks are called from the bench just after clock edges.
`timescale 1ns/1ps
`default_nettype none
module baseband_source
#(
  parameter int DW = 12
)(
  input  wire logic            clk_sys,
  output var logic signed [DW-1:0] in_a,
  output var logic signed [DW-1:0] in_b,
  output var logic             in_valid
);
  initial
  begin
    in_a = '0;
    in_b = '0;
    in_valid = 1'b0;
  end
  task automatic push(input logic signed [DW-1:0] a, b);
    @(posedge clk_sys);
    in_a     <= a;
    in_b     <= b;
    in_valid <= 1'b1;
  endtask
  // Idle lines flip so stale data can never pass as a match
  task automatic idle();
    @(posedge clk_sys);
    in_valid <= 1'b0;
    in_a     <= ~in_a;
    in_b     <= ~in_b;
  endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the transmit mixer and alignment chain.
// Assumes the source model drives samples and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import tx_mixer_pkg::*;
;
  localparam int DW = 12;
  logic                  clk_sys, reset, in_valid, dac_valid_q;
  logic signed [DW-1:0]  in_a, in_b, dac_i_q, dac_q_q;
  logic                  clkdiv_align_q, power_start_q;
  logic                  fine_freq_mixer_enable, droop_filter_enable;
  logic [FREQ_W-1:0]     fine_freq_word;
  logic [PHASE_W-1:0]    fine_phase_word;
  logic [1:0]            coarse_freq_mixer_mode, coarse_start_phase;
  logic [GAIN_W-1:0]     i_path_gain, q_path_gain;
  logic [PHB_W-1:0]      iq_phase_balance;
  logic [OFF_W-1:0]      a_path_dc_shift, b_path_dc_shift;
  logic                  offset_align_needed, align_pin_pos;
  logic                  tx_align_all_disable, tx_align_source_select;
  logic                  tx_align_reg_bit, power_enable, power_align_enable;
  logic [NBLK-1:0]       block_align_enable, block_align_source_select;
  logic [NBLK-1:0]       block_align_reg_bit;
  logic [PW_DELAY_W-1:0] power_align_delay;
  logic [2:0]            fifo_wr_ptr_q, fifo_rd_ptr_q;
  logic signed [DW-1:0]  oi[$], oq[$];
  int                    n_fail, num_checks, pw_n, pw_at, n_div;
  baseband_source #(.DW(DW)) src (.clk_sys, .in_a, .in_b, .in_valid);
  tx_mixer_correction_sync #(.DW(DW), .FIFO_AW(3)) dut (
    .clk_sys, .reset, .in_a, .in_b, .in_valid,
    .fine_freq_mixer_enable, .fine_freq_word, .fine_phase_word,
    .coarse_freq_mixer_mode, .coarse_start_phase, .droop_filter_enable,
    .i_path_gain, .q_path_gain, .iq_phase_balance,
    .a_path_dc_shift, .b_path_dc_shift, .offset_align_needed,
    .align_pin_pos, .tx_align_all_disable, .tx_align_source_select,
    .tx_align_reg_bit, .block_align_enable, .block_align_source_select,
    .block_align_reg_bit, .power_enable, .power_align_enable,
    .power_align_delay, .dac_i_q, .dac_q_q, .dac_valid_q,
    .clkdiv_align_q, .fifo_wr_ptr_q, .fifo_rd_ptr_q, .power_start_q
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Read half a cycle after launch so no edge race can mix old and new
  always @(negedge clk_sys)
  begin
    if (clkdiv_align_q === 1'b1)
      n_div++;
    if (dac_valid_q === 1'b1)
    begin
      oi.push_back(dac_i_q);
      oq.push_back(dac_q_q);
    end
    if (in_valid === 1'b1)
      pw_n++;
    if (power_start_q === 1'b1 && pw_at < 0)
      pw_at = pw_n;
  end
  task automatic give_verdict();
    if (n_fail == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic signed [DW-1:0] got, exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  function automatic logic signed [DW-1:0] pick(input int c);
    case (c)
      0: return 12'sh064;
      1: return 12'sh01E;
      2: return -12'sh064;
      default: return -12'sh01E;
    endcase
  endfunction
  task automatic send(input logic signed [DW-1:0] a, b, input int n);
    oi.delete();
    oq.delete();
    repeat (n) src.push(a, b);
    src.idle();
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic pin_align();
    align_pin_pos <= 1'b1;
    repeat (10) @(posedge clk_sys);
    align_pin_pos <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic t_pass();
    chk(DW'(fifo_rd_ptr_q), 12'h004, "rd ptr at reset");
    a_path_dc_shift <= 13'h0050;
    @(posedge clk_sys);
    send(12'sh064, -12'sh032, 1);
    chk(oi[0], 12'sh069, "offset immediate");
    chk(oq[0], -12'sh032, "pass without align");
    b_path_dc_shift <= -13'sh0050;
    send(12'sh7FF, 12'sh800, 1);
    chk(oi[0], 12'sh7FF, "positive clip");
    chk(oq[0], 12'sh800, "negative clip");
    a_path_dc_shift <= 13'h0000;
    b_path_dc_shift <= 13'h0000;
    @(posedge clk_sys);
  endtask
  task automatic t_coarse();
    int ti[4][4] = '{'{0,0,0,0}, '{0,2,0,2}, '{0,3,2,1}, '{0,1,2,3}};
    int tq[4][4] = '{'{1,1,1,1}, '{1,3,1,3}, '{1,0,3,2}, '{1,2,3,0}};
    for (int m = 0; m < 4; m++)
    begin
      coarse_freq_mixer_mode <= 2'(m);
      pin_align();
      chk(DW'(fifo_rd_ptr_q), 12'h004, "rd ptr after align");
      send(12'sh064, 12'sh01E, 4);
      for (int k = 0; k < 4; k++)
      begin
        chk(oi[k], pick(ti[m][k]), "coarse i");
        chk(oq[k], pick(tq[m][k]), "coarse q");
      end
    end
    coarse_freq_mixer_mode <= COARSE_POSQ;
    coarse_start_phase <= 2'h2;
    pin_align();
    send(12'sh064, 12'sh01E, 1);
    chk(oi[0], -12'sh064, "coarse start i");
    chk(oq[0], -12'sh01E, "coarse start q");
    coarse_start_phase <= 2'h0;
    coarse_freq_mixer_mode <= COARSE_NONE;
  endtask
  task automatic t_fine_droop();
    fine_phase_word <= 20'h40000;
    pin_align();
    fine_freq_mixer_enable <= 1'b1;
    send(12'sh3E8, 12'sh000, 1);
    chk(oi[0], 12'sh000, "fine i quarter turn");
    chk(oq[0], 12'sh3E7, "fine q quarter turn");
    fine_freq_word <= 32'h4000_0000;
    fine_phase_word <= 20'h00000;
    pin_align();
    send(12'sh3E8, 12'sh000, 2);
    chk(oi[0], 12'sh3E7, "fine i zero phase");
    chk(oi[1], 12'sh000, "fine i one step");
    chk(oq[1], 12'sh3E7, "fine q one step");
    fine_freq_word <= 32'h0000_0000;
    fine_freq_mixer_enable <= 1'b0;
    droop_filter_enable <= 1'b1;
    send(12'sh0C8, 12'sh0C8, 12);
    chk(oi[11], 12'sh0C8, "droop unity at dc");
    droop_filter_enable <= 1'b0;
  endtask
  task automatic t_gain();
    tx_align_source_select <= 1'b1;
    offset_align_needed <= 1'b1;
    i_path_gain <= 11'h200;
    iq_phase_balance <= 10'h100;
    a_path_dc_shift <= 13'h0030;
    send(12'sh064, 12'sh050, 1);
    chk(oi[0], 12'sh064, "held before align");
    tx_align_reg_bit <= 1'b1;
    repeat (6) @(posedge clk_sys);
    tx_align_reg_bit <= 1'b0;
    send(12'sh064, 12'sh050, 1);
    chk(oi[0], 12'sh03A, "loaded on align");
    chk(oq[0], 12'sh050, "q gain unity");
  endtask
  task automatic t_block_power();
    tx_align_all_disable <= 1'b1;
    block_align_enable <= 7'h7F;
    block_align_source_select <= 7'h7F;
    @(posedge clk_sys);
    n_div = 0;
    block_align_reg_bit <= 7'h01;
    repeat (3) @(posedge clk_sys);
    block_align_reg_bit <= 7'h03;
    repeat (3) @(posedge clk_sys);
    chk(DW'(fifo_wr_ptr_q), 12'h000, "block wr ptr");
    chk(DW'(fifo_rd_ptr_q), 12'h004, "block rd ptr");
    chk(DW'(n_div), 12'h001, "one divider pulse");
    power_align_delay <= 9'h001;
    power_align_enable <= 1'b1;
    power_enable <= 1'b1;
    block_align_reg_bit <= 7'h43;
    @(posedge clk_sys);
    pw_n = 0;
    pw_at = -1;
    send(12'sh000, 12'sh000, 20);
    chk(DW'(pw_at >= 12 && pw_at <= 14), 12'h001, "power delay");
    power_enable <= 1'b0;
    power_align_enable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    power_enable <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask
  initial
  begin
    reset = 1'b1;
    {fine_freq_mixer_enable, droop_filter_enable, align_pin_pos} = '0;
    {fine_freq_word, fine_phase_word, iq_phase_balance} = '0;
    {coarse_freq_mixer_mode, coarse_start_phase} = '0;
    {a_path_dc_shift, b_path_dc_shift, offset_align_needed} = '0;
    {tx_align_all_disable, tx_align_source_select, tx_align_reg_bit} = '0;
    {block_align_enable, block_align_source_select} = '0;
    {block_align_reg_bit, power_enable, power_align_enable} = '0;
    power_align_delay = '0;
    i_path_gain = GAIN_UNITY;
    q_path_gain = GAIN_UNITY;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    t_pass();
    t_coarse();
    t_fine_droop();
    t_gain();
    t_block_power();
    give_verdict();
  end
  initial
  begin
    #200us;
    n_fail++;
    $display("FAIL %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
`default_nettype wire
